// ---- design/nic_irq_map.svh ----
// offsets, field positions, reset values and bit groups for the status block
// Functional notes
// - bit 0 is OR of masked visible events, drives irq line, cleared by ack.
// - bit 1 sets on bus target abort or master abort.
// - bus fault clears only on full reset with transfer engine bit clear.
// - bit 2 sets on notified good send or any send error.
// - send-done acknowledged by writing the send result register.
// - bit 4 sets while complete frames sit in receive FIFO.
// - upload engine auto-acknowledges frame-arrived as it delivers frames.
// - bit 5 sets when top frame byte count exceeds threshold.
// - top frame complete drops partial flag, raises frame-arrived.
// - partial-frame flag clears on flag clear with its ack bit.
// - bit 6 sets on soft request or countdown expiry; ack clears it.
// - bit 7 sets when a counter nears full; clears when all read.
// - bit 8 sets on entering or leaving the link-up state.
// - link change clears on extra-status read, auto-ack read, or ack.
// - link change raised regardless of transceiver choice.
// - bit 9 sets on download complete with fetch-notify set.
// - fetch-done clears on flag clear with its bit set.
// - bit 10 sets on upload complete; flag clear with bit clears it.
// - bit 12 high while a multi-cycle command still executes.
// - bits 15:13 show bank index, zero after reset or full reset.
// - port 1e mirrors status word; reading it clears irq source mask.
// - auto-ack read clears fetch, deliver, partial, soft, line, link flags.
// - event bit reads set only when its visibility mask bit is set.
// - visible event drives irq only when its source mask bit set.
`ifndef NIC_IRQ_MAP_SVH
`define NIC_IRQ_MAP_SVH
`define OFS_STATUS_WORD    8'h0E
`define OFS_STATUS_ACK     8'h1E
`define BIT_LINE           0
`define BIT_BUS_FAULT      1
`define BIT_SEND_DONE      2
`define BIT_FRAME_ARRIVED  4
`define BIT_PARTIAL        5
`define BIT_SOFT_IRQ       6
`define BIT_COUNTER_FULL   7
`define BIT_LINK_CHANGE    8
`define BIT_FETCH_DONE     9
`define BIT_DELIVER_DONE   10
`define BIT_CMD_PENDING    12
`define MASK_RESET         16'h0000
`define EVENT_BITS         16'h07F6
`define AUTO_ACK_BITS      16'h0761
`endif

// ---- design/nic_irq_pkg.sv ----
// types shared by the status block
package nic_irq_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      PEND_IDLE,
      PEND_BUSY
   } pend_state_t;
endpackage : nic_irq_pkg

// ---- design/event_flag.sv ----
// one sticky event flag, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module event_flag (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // set and clear
   input  wire logic setEv,
   input  wire logic clrEv,
   // flag
   output logic      flag
);
   logic next_flag;
   always_comb begin
      next_flag = flag;
      if (clrEv) begin
         next_flag = 1'b0;
      end
      if (setEv) begin
         next_flag = 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end
   setwins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      setEv |=> flag) else $error("set lost");
endmodule : event_flag
`default_nettype wire

// ---- design/cmd_tracker.sv ----
// tracks a multi-cycle command from issue to completion
`timescale 1ns/10ps
`default_nettype none
module cmd_tracker
   import nic_irq_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // command events
   input  wire logic cmdStart,
   input  wire logic cmdDone,
   // status
   output logic      pending
);
   pend_state_t state;
   pend_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         PEND_IDLE: begin
            if (cmdStart && !cmdDone) begin
               next_state = PEND_BUSY;
            end
         end
         PEND_BUSY: begin
            if (cmdDone) begin
               next_state = PEND_IDLE;
            end
         end
         default: begin
            next_state = PEND_IDLE;
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= PEND_IDLE;
      end else begin
         state <= next_state;
      end
   end
   assign pending = (state == PEND_BUSY);
endmodule : cmd_tracker
`default_nettype wire

// ---- design/nic_interrupt_status.sv ----
// event flags, two-level masking, status ports and host interrupt line
`timescale 1ns/10ps
`default_nettype none
`include "nic_irq_map.svh"
module nic_interrupt_status
   import nic_irq_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // host register reads
   input  wire logic       rdStrobe,
   input  wire logic [7:0] rdOffset,
   output logic     [15:0] rdData,
   // host commands
   input  wire logic       fullReset,
   input  wire logic       fullResetEngineBit,
   input  wire logic       clearCmd,
   input  wire logic [10:0] clearBits,
   input  wire logic       setVisible,
   input  wire logic       setSource,
   input  wire logic [15:0] maskValue,
   input  wire logic       sendResultWrite,
   input  wire logic       extraStatusRead,
   input  wire logic       bankSelect,
   input  wire logic [2:0] bankValue,
   input  wire logic       softIrqCmd,
   input  wire logic       cmdStart,
   // engine events
   input  wire logic       busAbort,
   input  wire logic       sendNotified,
   input  wire logic       sendError,
   input  wire logic       framesInFifo,
   input  wire logic       frameUploaded,
   input  wire logic [15:0] topFrameBytes,
   input  wire logic [15:0] partialThreshold,
   input  wire logic       topFrameComplete,
   input  wire logic       countdownExpired,
   input  wire logic       counterNearFull,
   input  wire logic       allCountersRead,
   input  wire logic       linkUpEnter,
   input  wire logic       linkUpLeave,
   input  wire logic       fetchNotifyDone,
   input  wire logic       deliverDone,
   input  wire logic       cmdDone,
   // interrupt line and mask views
   output logic            irqLine,
   output logic     [15:0] visibleMask,
   output logic     [15:0] sourceMask,
   output logic            cmdPending
);
   logic [15:0] flags;
   logic [15:0] setEv;
   logic [15:0] clrEv;
   logic [15:0] visible;
   logic        lineActive;
   logic        next_lineActive;
   logic        pending;
   logic        autoRead;
   logic        plainRead;
   logic [15:0] next_visibleMask;
   logic [15:0] next_sourceMask;
   logic [15:0] next_rdData;
   logic [2:0]  bankIndex;
   logic [2:0]  next_bankIndex;
   logic        next_irqLine;
   logic        earlyOver;

   assign autoRead  = rdStrobe && (rdOffset == `OFS_STATUS_ACK);
   assign plainRead = rdStrobe && (rdOffset == `OFS_STATUS_WORD);
   assign earlyOver = (topFrameBytes > partialThreshold);

   always_comb begin
      setEv = 16'h0000;
      clrEv = 16'h0000;
      setEv[`BIT_BUS_FAULT] = busAbort;
      // only full reset without engine bit
      clrEv[`BIT_BUS_FAULT] = fullReset && !fullResetEngineBit;
      setEv[`BIT_SEND_DONE] = sendNotified || sendError;
      clrEv[`BIT_SEND_DONE] = sendResultWrite;
      setEv[`BIT_FRAME_ARRIVED] = framesInFifo || topFrameComplete;
      // upload auto-ack; complete frame drops partial flag
      clrEv[`BIT_FRAME_ARRIVED] = frameUploaded;
      // threshold crossing while top frame still arriving
      setEv[`BIT_PARTIAL] = earlyOver && !topFrameComplete;
      clrEv[`BIT_PARTIAL] = topFrameComplete || autoRead
         || (clearCmd && clearBits[`BIT_PARTIAL]);
      setEv[`BIT_SOFT_IRQ] = softIrqCmd || countdownExpired;
      clrEv[`BIT_SOFT_IRQ] = autoRead
         || (clearCmd && clearBits[`BIT_SOFT_IRQ]);
      setEv[`BIT_COUNTER_FULL] = counterNearFull;
      clrEv[`BIT_COUNTER_FULL] = allCountersRead;
      setEv[`BIT_LINK_CHANGE] = linkUpEnter || linkUpLeave;
      clrEv[`BIT_LINK_CHANGE] = extraStatusRead || autoRead
         || (clearCmd && clearBits[`BIT_LINK_CHANGE]);
      setEv[`BIT_FETCH_DONE] = fetchNotifyDone;
      clrEv[`BIT_FETCH_DONE] = autoRead
         || (clearCmd && clearBits[`BIT_FETCH_DONE]);
      setEv[`BIT_DELIVER_DONE] = deliverDone;
      clrEv[`BIT_DELIVER_DONE] = autoRead
         || (clearCmd && clearBits[`BIT_DELIVER_DONE]);
   end

   genvar gi;
   generate
      for (gi = 1; gi <= `BIT_DELIVER_DONE; gi++) begin : g_flag
         if (gi != 3) begin : g_used
            event_flag u_flag (
               .ref_clk (ref_clk),
               .rst_n   (rst_n),
               .setEv   (setEv[gi]),
               .clrEv   (clrEv[gi]),
               .flag    (flags[gi])
            );
         end else begin : g_hole
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate
   assign flags[0]     = 1'b0;
   assign flags[15:11] = 5'h00;

   cmd_tracker u_cmd (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .cmdStart (cmdStart),
      .cmdDone  (cmdDone),
      .pending  (pending)
   );

   assign visible = flags & visibleMask & `EVENT_BITS;

   always_comb begin
      next_visibleMask = visibleMask;
      next_sourceMask  = sourceMask;
      next_bankIndex   = bankIndex;
      next_lineActive  = lineActive;
      if (setVisible) begin
         next_visibleMask = maskValue & `EVENT_BITS;
      end
      if (setSource) begin
         next_sourceMask = maskValue & `EVENT_BITS;
      end
      if (autoRead) begin
         next_sourceMask = `MASK_RESET;
      end
      if (bankSelect) begin
         next_bankIndex = bankValue;
      end
      // bank back to zero on full reset
      if (fullReset) begin
         next_bankIndex = 3'h0;
      end
      // line latch cleared by ack or auto read
      if (autoRead || (clearCmd && clearBits[`BIT_LINE])) begin
         next_lineActive = 1'b0;
      end
      // masked sources set the line, set beats clear
      // uses the mask as it will stand, so an auto read that wipes the
      // mask cannot re-latch the line it is acknowledging
      if (|(visible & next_sourceMask)) begin
         next_lineActive = 1'b1;
      end
      next_irqLine = next_lineActive;
      next_rdData  = rdData;
      if (plainRead || autoRead) begin
         next_rdData = {bankIndex, pending, 1'b0, visible[10:1], lineActive};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         visibleMask <= `MASK_RESET;
         sourceMask  <= `MASK_RESET;
         bankIndex   <= 3'h0;
         lineActive  <= 1'b0;
         irqLine     <= 1'b0;
         rdData      <= 16'h0000;
         cmdPending  <= 1'b0;
      end else begin
         visibleMask <= next_visibleMask;
         sourceMask  <= next_sourceMask;
         bankIndex   <= next_bankIndex;
         lineActive  <= next_lineActive;
         irqLine     <= next_irqLine;
         rdData      <= next_rdData;
         cmdPending  <= pending;
      end
   end

   busfault_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      flags[1] && !(fullReset && !fullResetEngineBit) |=> flags[1])
      else $error("bus fault cleared early");
   line_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      |(visible & sourceMask) && !autoRead |=> irqLine)
      else $error("line not raised");
   auto_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      autoRead |=> sourceMask == 16'h0000)
      else $error("mask not cleared");
   holes_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rdData[3] == 1'b0 && rdData[11] == 1'b0)
      else $error("hole bit set");
   hidden_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (plainRead && !visibleMask[2]) |=> !rdData[2])
      else $error("hidden bit read");
   bank_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fullReset |=> bankIndex == 3'h0)
      else $error("bank not reset");
   send_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      sendError |=> flags[2])
      else $error("send flag missed");
   link_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      autoRead && !linkUpEnter && !linkUpLeave |=> !flags[8])
      else $error("link not cleared");
endmodule : nic_interrupt_status
`default_nettype wire

// ---- dv/host_model.sv ----
// host driver model: status reads and one-cycle commands
`timescale 1ns/10ps
`default_nettype none
module host_model
   import nic_irq_pkg::*;
(
   // clock
   input  wire logic        ref_clk,
   // status feedback
   input  wire logic [15:0] rdData,
   input  wire logic        cmdPending,
   // read port
   output logic             rdStrobe,
   output logic      [7:0]  rdOffset,
   // command pulses and their argument
   output logic      [7:0]  pulse,
   output logic      [15:0] arg
);
   initial begin
      rdStrobe = 1'b0;
      rdOffset = 8'h00;
      pulse    = 8'h00;
      arg      = 16'h0000;
   end
   task automatic hostRead(input logic [7:0] ofs, output word_t d);
      @(posedge ref_clk);
      rdStrobe <= 1'b1;
      rdOffset <= ofs;
      @(posedge ref_clk);
      rdStrobe <= 1'b0;
      // idle offset is scrambled so nothing leans on a stale address
      rdOffset <= ~ofs;
      @(posedge ref_clk);
      d = rdData;
   endtask : hostRead
   // wait out a busy command first
   task automatic hostCmd(input int which, input word_t a);
      int n;
      n = 0;
      @(posedge ref_clk);
      while (cmdPending !== 1'b0 && n < 100) begin
         n++;
         @(posedge ref_clk);
      end
      pulse <= 8'h01 << which;
      arg   <= a;
      @(posedge ref_clk);
      pulse <= 8'h00;
      arg   <= ~a;
   endtask : hostCmd
endmodule : host_model
`default_nettype wire

// ---- dv/nic_interrupt_status_tb.sv ----
// self-checking bench for the interrupt status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
   mismatches++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module nic_interrupt_status_tb
   import nic_irq_pkg::*;
();
   logic        ref_clk;
   logic        rst_n;
   logic [14:0] ev;
   logic [15:0] bytes;
   logic [15:0] thr;
   logic [15:0] rdData;
   logic [15:0] visibleMask;
   logic [15:0] sourceMask;
   logic [15:0] arg;
   logic [7:0]  rdOffset;
   logic [7:0]  pulse;
   logic        rdStrobe;
   logic        irqLine;
   logic        cmdPending;
   word_t       d;
   int          mismatches;
   int          checks_done;
   int          bitOf[12] = '{1, 2, 2, 4, 4, 6, 7, 8, 8, 9, 10, 6};
   int          clrOf[12] = '{0, 3, 3, 12, 12, 0, 13, 4, 0, 0, 0, 0};
   nic_interrupt_status dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .rdStrobe(rdStrobe), .rdOffset(rdOffset), .rdData(rdData),
      .fullReset(pulse[6]), .fullResetEngineBit(arg[0]),
      .clearCmd(pulse[0]), .clearBits(arg[10:0]),
      .setVisible(pulse[1]), .setSource(pulse[2]), .maskValue(arg),
      .sendResultWrite(pulse[3]), .extraStatusRead(pulse[4]),
      .bankSelect(pulse[5]), .bankValue(arg[2:0]),
      .softIrqCmd(ev[11]), .cmdStart(pulse[7]),
      .busAbort(ev[0]), .sendNotified(ev[1]), .sendError(ev[2]),
      .framesInFifo(ev[3]), .frameUploaded(ev[12]),
      .topFrameBytes(bytes), .partialThreshold(thr),
      .topFrameComplete(ev[4]), .countdownExpired(ev[5]),
      .counterNearFull(ev[6]), .allCountersRead(ev[13]),
      .linkUpEnter(ev[7]), .linkUpLeave(ev[8]),
      .fetchNotifyDone(ev[9]), .deliverDone(ev[10]), .cmdDone(ev[14]),
      .irqLine(irqLine), .visibleMask(visibleMask),
      .sourceMask(sourceMask), .cmdPending(cmdPending));
   host_model host_u (
      .ref_clk(ref_clk), .rdData(rdData), .cmdPending(cmdPending),
      .rdStrobe(rdStrobe), .rdOffset(rdOffset), .pulse(pulse), .arg(arg));
   task automatic pulseEv(input logic [14:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 15'h0000;
   endtask : pulseEv
   task automatic rd(input logic [7:0] o, input word_t e, input string n);
      host_u.hostRead(o, d);
      `CHK(n, e, d)
   endtask : rd
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end
   initial begin
      rst_n = 1'b0;
      ev = 15'h0000;
      bytes = 16'h0000;
      thr = 16'h0063;
      mismatches = 0;
      checks_done = 0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h0E, 16'h0000, "reset");
      `CHK("masks", 32'h0, {visibleMask, sourceMask})
      host_u.hostCmd(5, 16'h0005);
      rd(8'h0E, 16'hA000, "bank");
      rd(8'h10, 16'hA000, "unmapped");
      host_u.hostCmd(6, 16'h0001);
      rd(8'h0E, 16'h0000, "bankrst");
      $display("test bank done");
      host_u.hostCmd(1, 16'hFFFF);
      pulseEv(15'h0001);
      repeat (3) @(posedge ref_clk);
      #1 `CHK("irqmask", 1'b0, irqLine)
      host_u.hostCmd(2, 16'h0002);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("irq", 1'b1, irqLine)
      rd(8'h0E, 16'h0003, "fault");
      rd(8'h1E, 16'h0003, "auto");
      `CHK("src", 16'h0000, sourceMask)
      rd(8'h0E, 16'h0002, "kept");
      `CHK("irqoff", 1'b0, irqLine)
      host_u.hostCmd(6, 16'h0001);
      rd(8'h0E, 16'h0002, "engine");
      host_u.hostCmd(6, 16'h0000);
      rd(8'h0E, 16'h0000, "faultclr");
      $display("test fault done");
      host_u.hostCmd(1, 16'hFFFF);
      for (int i = 1; i < 12; i++) begin
         pulseEv(15'(1 << i));
         rd(8'h0E, word_t'(1 << bitOf[i]), "set");
         if (clrOf[i] >= 12) pulseEv(15'(1 << clrOf[i]));
         else host_u.hostCmd(clrOf[i], word_t'(1 << bitOf[i]));
         rd(8'h0E, 16'h0000, "clr");
      end
      $display("test events done");
      bytes <= 16'h0063;
      rd(8'h0E, 16'h0000, "equal");
      bytes <= 16'h0064;
      repeat (2) @(posedge ref_clk);
      rd(8'h0E, 16'h0020, "early");
      bytes <= 16'h0000;
      pulseEv(15'h0010);
      rd(8'h0E, 16'h0010, "complete");
      pulseEv(15'h1000);
      bytes <= 16'h0064;
      repeat (2) @(posedge ref_clk);
      bytes <= 16'h0000;
      host_u.hostCmd(0, 16'h0020);
      rd(8'h0E, 16'h0000, "partack");
      bytes <= 16'h0064;
      pulseEv(15'h0E8C);
      bytes <= 16'h0000;
      rd(8'h1E, 16'h0774, "autoall");
      rd(8'h0E, 16'h0014, "left");
      host_u.hostCmd(3, 16'h0000);
      pulseEv(15'h1000);
      $display("test receive done");
      host_u.hostCmd(1, 16'h0004);
      pulseEv(15'h0084);
      rd(8'h0E, 16'h0004, "hidden");
      host_u.hostCmd(3, 16'h0000);
      host_u.hostCmd(0, 16'h0100);
      host_u.hostCmd(7, 16'h0000);
      repeat (2) @(posedge ref_clk);
      #1 `CHK("pend", 1'b1, cmdPending)
      rd(8'h0E, 16'h1000, "busy");
      pulseEv(15'h4000);
      rd(8'h0E, 16'h0000, "idle");
      $display("test mask and command done");
      summarize();
   end
endmodule : nic_interrupt_status_tb
`default_nettype wire
